// File: ftm_top.v
// Fan tach monitor: speed count, out-of-range flags, spin-up retries, fault pin.
// Assumes a classic Wishbone master and a tach pin from outside the clock domain.
`timescale 1ns/100ps
`include "ftm_defs.vh"
module ftm_top #(
	parameter integer FAST_TICKS      = `FTM_FAST_MS * (`FTM_REF_HZ / `FTM_MS_PER_S),
	parameter integer SLOW_TICKS      = `FTM_SLOW_MS * (`FTM_REF_HZ / `FTM_MS_PER_S),
	parameter integer SPIN_UNIT_TICKS = `FTM_SPIN_UNIT_MS * (`FTM_REF_HZ / `FTM_MS_PER_S)
) (
	// Clock and reset
	input  wire        mclk_i,
	input  wire        rst_n_i,
	// Wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [4:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	// Fan
	input  wire        tach_i,
	output reg         pwm_o,
	// Open-drain fault and alert pins
	output wire        fault_o,
	output reg         fault_oe_o,
	output wire        alert_o,
	output reg         alert_oe_o
);
	localparam [1:0] S_IDLE = 2'h0;
	localparam [1:0] S_ARM  = 2'h1;
	localparam [1:0] S_CNT  = 2'h2;
	localparam [1:0] S_EVAL = 2'h3;
	localparam [19:0] FAST_LEN = FAST_TICKS[19:0];
	localparam [19:0] SLOW_LEN = SLOW_TICKS[19:0];

	// ==========================================================
	// Helpers
	function [31:0] bmerge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  sel;
		integer i;
		begin
			for (i = 0; i < 4; i = i + 1) begin
				bmerge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
			end
		end
	endfunction

	function [5:0] spin_mult;
		input [2:0] sel;
		begin
			case (sel)
				3'h0: spin_mult = 6'h01;
				3'h1: spin_mult = 6'h02;
				3'h2: spin_mult = 6'h03;
				3'h3: spin_mult = 6'h04;
				3'h4: spin_mult = 6'h05;
				3'h5: spin_mult = 6'h0a;
				3'h6: spin_mult = 6'h14;
				default: spin_mult = 6'h28;
			endcase
		end
	endfunction

	// ==========================================================
	// Enables and tach synchroniser
	wire ref_tick;
	wire pwm_tick;

	ftm_tick_div #(.DIV(`FTM_CLK_HZ / `FTM_REF_HZ)) u_ref_div (
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n_i),
		.tick_o  (ref_tick)
	);

	ftm_tick_div #(.DIV(`FTM_PWM_DIV)) u_pwm_div (
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n_i),
		.tick_o  (pwm_tick)
	);

	reg tach_s1_q;
	reg tach_s2_q;
	reg tach_s3_q;
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			// Idle high like the pulled-up pin, so reset gives no false edge
			tach_s1_q <= 1'b1;
			tach_s2_q <= 1'b1;
			tach_s3_q <= 1'b1;
		end else begin
			tach_s1_q <= tach_i;
			tach_s2_q <= tach_s1_q;
			tach_s3_q <= tach_s2_q;
		end
	end
	wire tach_rise = tach_s2_q & ~tach_s3_q;

	// ==========================================================
	// Registers and bus
	reg [15:0] ctrl_q;
	reg [7:0]  duty_q;
	reg [15:0] low_lim_q;
	reg [15:0] high_lim_q;
	reg [15:0] speed_q;
	reg [7:0]  hi_hold_q;
	reg        hi_frozen_q;
	reg        slow_q;
	reg        over_q;
	reg        over_arm_q;
	reg        fail_q;
	reg        spin_q;

	wire       start_b   = ctrl_q[`FTM_C_START];
	wire       tach_en   = ctrl_q[`FTM_C_TACH_EN];
	wire       tach_mode = ctrl_q[`FTM_C_TACH_MODE];
	wire       fast_b    = ctrl_q[`FTM_C_FAST];
	wire       ppr_b     = ctrl_q[`FTM_C_PPR];
	wire       irq_en    = ctrl_q[`FTM_C_IRQ_EN];
	wire       fault_en  = ctrl_q[`FTM_C_FAULT_EN];
	wire       spin_dis  = ctrl_q[`FTM_C_SPIN_DIS];
	wire [1:0] mode      = ctrl_q[`FTM_C_MODE_HI:`FTM_C_MODE_LO];
	wire [2:0] stime     = ctrl_q[`FTM_C_STIME_HI:`FTM_C_STIME_LO];

	wire       mon_en    = start_b & tach_en;
	wire       acc       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire       wr        = acc & wb_we_i;
	wire       rd        = acc & ~wb_we_i;
	wire [2:0] idx       = wb_adr_i[4:2];
	wire       rd_status = rd & (idx == `FTM_IDX_STATUS);
	wire       rd_lo     = rd & (idx == `FTM_IDX_SPEED_LO);
	wire       rd_hi     = rd & (idx == `FTM_IDX_SPEED_HI);
	wire [31:0] wmerged  = bmerge(32'h0, wb_dat_i, wb_sel_i);
	wire [31:0] ctrl_nx  = bmerge({16'h0, ctrl_q}, wmerged, wb_sel_i);
	wire [31:0] low_nx   = bmerge({16'h0, low_lim_q}, wmerged, wb_sel_i);
	wire [31:0] high_nx  = bmerge({16'h0, high_lim_q}, wmerged, wb_sel_i);

	reg [31:0] rdata;
	always @* begin
		rdata = 32'h0;
		case (idx)
			`FTM_IDX_CTRL:     rdata[15:0] = ctrl_q;
			`FTM_IDX_DUTY:     rdata[7:0]  = duty_q;
			`FTM_IDX_LOW_LIM:  rdata[15:0] = low_lim_q;
			`FTM_IDX_HIGH_LIM: rdata[15:0] = high_lim_q;
			`FTM_IDX_STATUS: begin
				rdata[`FTM_S_SLOW] = slow_q;
				rdata[`FTM_S_OVER] = over_q;
				rdata[`FTM_S_FAIL] = fail_q;
				rdata[`FTM_S_SPIN] = spin_q;
				rdata[`FTM_S_MON]  = mon_en;
			end
			`FTM_IDX_SPEED_LO: rdata[7:0]  = speed_q[7:0];
			`FTM_IDX_SPEED_HI: rdata[7:0]  = hi_frozen_q ? hi_hold_q : speed_q[15:8];
			default:           rdata       = 32'h0;
		endcase
	end

	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wb_ack_o   <= 1'b0;
			wb_dat_o   <= 32'h0;
			ctrl_q     <= `FTM_CTRL_RST;
			duty_q     <= `FTM_DUTY_RST;
			low_lim_q  <= `FTM_LOW_LIM_RST;
			high_lim_q <= `FTM_HIGH_LIM_RST;
		end else begin
			wb_ack_o <= acc;
			wb_dat_o <= rd ? rdata : 32'h0;
			if (wr) begin
				case (idx)
					`FTM_IDX_CTRL:     ctrl_q     <= ctrl_nx[15:0] & `FTM_CTRL_MASK;
					`FTM_IDX_DUTY:     duty_q     <= wb_sel_i[0] ? wb_dat_i[7:0] : duty_q;
					`FTM_IDX_LOW_LIM:  low_lim_q  <= low_nx[15:0];
					`FTM_IDX_HIGH_LIM: high_lim_q <= high_nx[15:0];
					default: begin
					end
				endcase
			end
		end
	end

	// ==========================================================
	// Duty shaping
	wire low_rpm  = ~tach_mode & (mode == `FTM_MODE_RPM) & (duty_q < `FTM_DUTY_MIN_RPM);
	wire low_open = ~tach_mode & tach_en & (mode != `FTM_MODE_RPM) & (duty_q < `FTM_DUTY_MIN_OPEN);
	wire upd_ok   = ~low_open;

	reg [7:0] duty_eff;
	always @* begin
		duty_eff = duty_q;
		if (spin_q) begin
			duty_eff = `FTM_DUTY_FULL;
		end else if (low_rpm) begin
			duty_eff = `FTM_DUTY_MIN_RPM;
		end else if (low_open) begin
			duty_eff = 8'h00;
		end
	end

	// ==========================================================
	// Measurement
	reg [1:0]  state_q;
	reg [15:0] cnt_q;
	reg [2:0]  edges_q;
	reg [19:0] ivl_q;
	reg        meas_req_q;
	reg [19:0] spin_cnt_q;
	reg [2:0]  spin_num_q;

	wire [2:0]  npulse   = ppr_b ? `FTM_PULSES_4 : `FTM_PULSES_2;
	wire [19:0] ivl_len  = fast_b ? FAST_LEN : SLOW_LEN;
	wire        ivl_done = ref_tick & (ivl_q >= ivl_len - 20'h1);
	wire [31:0] spin_prod = SPIN_UNIT_TICKS * spin_mult(stime);
	wire [19:0] spin_len = spin_prod[19:0];
	wire        slow_det = cnt_q > low_lim_q;
	wire        over_det = cnt_q < high_lim_q;
	wire        eval     = (state_q == S_EVAL) & upd_ok;
	wire        spin_end = spin_q & ref_tick & (spin_cnt_q == 20'h0);
	wire        spin_go  = eval & slow_det & ~spin_dis & ~spin_q;
	wire        measuring = (state_q == S_ARM) | (state_q == S_CNT);

	// Interval keeps running through spin-up so the monitoring rate stays fixed
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ivl_q <= 20'h0;
		end else if (!mon_en) begin
			ivl_q <= 20'h0;
		end else if (ivl_done) begin
			ivl_q <= 20'h0;
		end else if (ref_tick) begin
			ivl_q <= ivl_q + 20'h1;
		end
	end

	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= S_IDLE;
			cnt_q   <= 16'h0;
			edges_q <= 3'h0;
		end else if (!mon_en) begin
			state_q <= S_IDLE;
		end else begin
			case (state_q)
				S_IDLE: begin
					if ((ivl_done | meas_req_q) & ~spin_q & upd_ok) begin
						state_q <= S_ARM;
						cnt_q   <= 16'h0;
						edges_q <= 3'h0;
					end
				end
				S_ARM: begin
					// A stopped fan saturates here and reads as slow unless the low limit is 16'hffff
					if (tach_rise) begin
						state_q <= S_CNT;
						cnt_q   <= 16'h0;
					end else if (ref_tick) begin
						if (cnt_q == `FTM_CNT_MAX) begin
							state_q <= S_EVAL;
						end else begin
							cnt_q <= cnt_q + 16'h1;
						end
					end
				end
				S_CNT: begin
					if (tach_rise && (edges_q + 3'h1 == npulse)) begin
						state_q <= S_EVAL;
					end else begin
						if (tach_rise) begin
							edges_q <= edges_q + 3'h1;
						end
						if (ref_tick) begin
							if (cnt_q == `FTM_CNT_MAX) begin
								state_q <= S_EVAL;
							end else begin
								cnt_q <= cnt_q + 16'h1;
							end
						end
					end
				end
				S_EVAL: begin
					state_q <= S_IDLE;
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Results, flags, spin-up and failure
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			speed_q     <= `FTM_SPEED_RST;
			hi_hold_q   <= 8'h0;
			hi_frozen_q <= 1'b0;
			slow_q      <= 1'b0;
			over_q      <= 1'b0;
			over_arm_q  <= 1'b1;
			fail_q      <= 1'b0;
			spin_q      <= 1'b0;
			spin_cnt_q  <= 20'h0;
			spin_num_q  <= 3'h0;
			meas_req_q  <= 1'b0;
		end else begin
			if (eval) begin
				speed_q <= cnt_q;
			end
			if (rd_lo) begin
				hi_hold_q   <= speed_q[15:8];
				hi_frozen_q <= 1'b1;
			end else if (rd_hi) begin
				hi_frozen_q <= 1'b0;
			end
			// Set beats the read-clear in the same cycle
			slow_q <= (eval & slow_det) | spin_end | (slow_q & ~rd_status);
			over_q <= (eval & over_det & over_arm_q) | (over_q & ~rd_status);
			if (eval) begin
				over_arm_q <= over_det ? 1'b0 : 1'b1;
			end
			if (eval & ~slow_det) begin
				spin_num_q <= 3'h0;
				fail_q     <= 1'b0;
			end else if (eval & slow_det & (spin_num_q == `FTM_SPIN_FAIL)) begin
				fail_q <= 1'b1;
			end
			if (spin_go) begin
				spin_q     <= 1'b1;
				spin_cnt_q <= spin_len - 20'h1;
				if (spin_num_q != `FTM_SPIN_FAIL) begin
					spin_num_q <= spin_num_q + 3'h1;
				end
			end else if (spin_end) begin
				spin_q     <= 1'b0;
				meas_req_q <= 1'b1;
			end else if (spin_q & ref_tick) begin
				spin_cnt_q <= spin_cnt_q - 20'h1;
			end
			if (state_q == S_ARM) begin
				meas_req_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// PWM with measurement hold and on-time repayment
	reg [7:0]  pcnt_q;
	reg [15:0] debt_q;

	wire nat_on = (duty_eff == `FTM_DUTY_FULL) | (pcnt_q < duty_eff);
	wire hold   = ~tach_mode & measuring;
	wire repay  = ~tach_mode & ~hold & nat_on & (debt_q != 16'h0);

	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pcnt_q <= 8'h0;
			debt_q <= 16'h0;
			pwm_o  <= 1'b0;
		end else begin
			if (pwm_tick) begin
				pcnt_q <= (pcnt_q == `FTM_PWM_LAST) ? 8'h0 : pcnt_q + 8'h1;
			end
			if (tach_mode) begin
				debt_q <= 16'h0;
			end else if (pwm_tick & hold & ~nat_on & (debt_q != `FTM_CNT_MAX)) begin
				debt_q <= debt_q + 16'h1;
			end else if (pwm_tick & repay) begin
				debt_q <= debt_q - 16'h1;
			end
			pwm_o <= hold | (nat_on & ~repay);
		end
	end

	// ==========================================================
	// Open-drain pins
	assign fault_o = 1'b0;
	assign alert_o = 1'b0;

	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fault_oe_o <= 1'b0;
			alert_oe_o <= 1'b0;
		end else begin
			fault_oe_o <= fault_en & fail_q;
			alert_oe_o <= irq_en & (slow_q | over_q);
		end
	end
endmodule

// File: ftm_defs.vh
// Constants for the fan tach monitor and fault block.
// Assumes inclusion by bare name from the design files.
`ifndef FTM_DEFS_VH
`define FTM_DEFS_VH

// ==========================================================
// Timing
`define FTM_CLK_HZ        50000000
`define FTM_REF_HZ        100000
`define FTM_FAST_MS       250
`define FTM_SLOW_MS       1000
`define FTM_SPIN_UNIT_MS  200
`define FTM_MS_PER_S      1000
`define FTM_PWM_DIV       8
`define FTM_PWM_LAST      8'hfe

// ==========================================================
// Register word indices (byte address = index * 4)
`define FTM_IDX_CTRL      3'h0
`define FTM_IDX_DUTY      3'h1
`define FTM_IDX_LOW_LIM   3'h2
`define FTM_IDX_HIGH_LIM  3'h3
`define FTM_IDX_STATUS    3'h4
`define FTM_IDX_SPEED_LO  3'h5
`define FTM_IDX_SPEED_HI  3'h6

// ==========================================================
// Control field positions
`define FTM_C_START       0
`define FTM_C_TACH_EN     1
`define FTM_C_TACH_MODE   2
`define FTM_C_FAST        3
`define FTM_C_PPR         4
`define FTM_C_IRQ_EN      5
`define FTM_C_FAULT_EN    6
`define FTM_C_SPIN_DIS    7
`define FTM_C_MODE_LO     8
`define FTM_C_MODE_HI     9
`define FTM_C_STIME_LO    10
`define FTM_C_STIME_HI    12
`define FTM_CTRL_RST      16'h1400
`define FTM_CTRL_MASK     16'h1fff

// Status field positions
`define FTM_S_SLOW        0
`define FTM_S_OVER        1
`define FTM_S_FAIL        2
`define FTM_S_SPIN        3
`define FTM_S_MON         4

// ==========================================================
// Values
`define FTM_MODE_RPM      2'h1
`define FTM_DUTY_MIN_RPM  8'h4d
`define FTM_DUTY_MIN_OPEN 8'h12
`define FTM_DUTY_FULL     8'hff
`define FTM_DUTY_RST      8'h00
`define FTM_LOW_LIM_RST   16'hffff
`define FTM_HIGH_LIM_RST  16'h0000
`define FTM_SPEED_RST     16'h0000
`define FTM_CNT_MAX       16'hffff
`define FTM_SPIN_FAIL     3'h5
`define FTM_PULSES_4      3'h4
`define FTM_PULSES_2      3'h2

`endif

// File: ftm_tick_div.v
// Free-running divider giving a one-cycle enable pulse every DIV clocks.
// Assumes DIV of at least 2.
`timescale 1ns/100ps
module ftm_tick_div #(
	parameter integer DIV = 2
) (
	// Clock and reset
	input  wire mclk_i,
	input  wire rst_n_i,
	// Enable pulse
	output reg  tick_o
);
	localparam integer W      = $clog2(DIV);
	localparam integer LAST_I = DIV - 1;
	localparam [W-1:0] LAST   = LAST_I[W-1:0];

	reg [W-1:0] cnt_q;

	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q  <= {W{1'b0}};
			tick_o <= 1'b0;
		end else if (cnt_q == LAST) begin
			cnt_q  <= {W{1'b0}};
			tick_o <= 1'b1;
		end else begin
			cnt_q  <= cnt_q + {{(W-1){1'b0}}, 1'b1};
			tick_o <= 1'b0;
		end
	end
endmodule

// File: ftm_top_asserts.sv
// Port checker for the fan tach monitor, bound to ftm_top.
// Assumes full byte enables on every register write.
`timescale 1ns/100ps
module ftm_chk (
	// Clock and reset
	input wire        mclk_i,
	input wire        rst_n_i,
	// Bus
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire        wb_we_i,
	input wire [4:0]  wb_adr_i,
	input wire [3:0]  wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire        wb_ack_o,
	// Fan and pins
	input wire        tach_i,
	input wire        pwm_o,
	input wire        fault_o,
	input wire        fault_oe_o,
	input wire        alert_o,
	input wire        alert_oe_o
);
	// ==========================================
	// Shadow of the control word
	logic [12:0] ctrl_q;
	wire         take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			ctrl_q <= 13'h1400;
		else if (take && wb_we_i && wb_adr_i[4:2] == 3'h0)
			ctrl_q <= wb_dat_i[12:0];
	end
	// ==========================================
	// Properties
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held past one cycle");
	a_ack_next: assert property (take |=> wb_ack_o)
		else $error("ack missing after request");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	a_unmapped_zero: assert property (take && !wb_we_i && wb_adr_i[4:2] == 3'h7 |=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_ctrl_readback: assert property (take && !wb_we_i && wb_adr_i[4:2] == 3'h0 |=> wb_dat_o == {19'h0, ctrl_q})
		else $error("control readback wrong");
	a_od_data_low: assert property (fault_o == 1'b0 && alert_o == 1'b0)
		else $error("open drain data not low");
	a_fault_gated: assert property (!ctrl_q[6] && !$past(ctrl_q[6]) |-> !fault_oe_o)
		else $error("fault pin driven while disabled");
	a_alert_gated: assert property (!ctrl_q[5] && !$past(ctrl_q[5]) |-> !alert_oe_o)
		else $error("alert driven while disabled");
	c_write: cover property (take && wb_we_i);
	c_fault: cover property ($rose(fault_oe_o));
	c_alert: cover property ($rose(alert_oe_o));
endmodule

bind ftm_top ftm_chk chk_u (
	.mclk_i(mclk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tach_i(tach_i), .pwm_o(pwm_o),
	.fault_o(fault_o), .fault_oe_o(fault_oe_o), .alert_o(alert_o), .alert_oe_o(alert_oe_o)
);

// File: ftm_fan_model.sv
// Fan model: tach toggles every half_i clocks while powered.
// Tach starts high from reset and holds its last level while the fan is stopped.
`timescale 1ns/100ps
module ftm_fan (
	// Clock and reset
	input  wire        mclk_i,
	input  wire        rst_n_i,
	// Power
	input  wire        en_i,
	input  wire        dc_i,
	input  wire        pwm_i,
	input  wire [11:0] half_i,
	// Tach
	output logic       tach_o
);
	logic [11:0] cnt_q;
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q <= 12'h0;
			tach_o <= 1'b1;
		end else if (en_i && (dc_i || pwm_i)) begin
			if (cnt_q >= half_i - 12'h1) begin
				cnt_q <= 12'h0;
				tach_o <= ~tach_o;
			end else
				cnt_q <= cnt_q + 12'h1;
		end
	end
endmodule

// File: tb.sv
// Self-checking bench for ftm_top with a fan model.
// Assumes shortened interval parameters; one ref tick is 500 clocks.
`timescale 1ns/100ps
module tb;
	localparam integer FAST = 20;
	logic        mclk_i;
	logic        rst_n_i;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [4:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat_w;
	wire  [31:0] dat_r;
	wire         ack, tach, pwm, f_o, f_oe, a_o, a_oe;
	logic        fan_en, fan_dc;
	logic [11:0] half;
	logic [31:0] q, d;
	integer      err_total, n_checks, i, p0;
	integer      pwm_hi = 0;
	logic [31:0] rst_v [8] = '{32'h1400, 32'h0, 32'hffff, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

	ftm_top #(.FAST_TICKS(FAST), .SLOW_TICKS(40), .SPIN_UNIT_TICKS(5)) dut_u (
		.mclk_i(mclk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
		.tach_i(tach), .pwm_o(pwm), .fault_o(f_o), .fault_oe_o(f_oe), .alert_o(a_o), .alert_oe_o(a_oe));
	ftm_fan fan_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .en_i(fan_en), .dc_i(fan_dc), .pwm_i(pwm),
		.half_i(half), .tach_o(tach));

	// ==========================================
	// Helpers
	always @(posedge mclk_i) if (pwm === 1'b1) pwm_hi <= pwm_hi + 1;
	function automatic logic [31:0] exp_cnt(input logic ppr, input logic [11:0] h);
		return (ppr ? 32'h4 : 32'h2) * {20'h0, h} * 2 / 500;
	endfunction
	task end_sim;
		if (err_total == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks = n_checks + 1;
		if (got !== exp) begin
			err_total = err_total + 1;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Classic cycle: hold until ack is sampled, then release
	task xfer(input logic w, input logic [2:0] idx, input logic [31:0] wd, output logic [31:0] rd);
		integer n;
		@(posedge mclk_i);
		{cyc, stb, we, adr, dat_w} <= {1'b1, 1'b1, w, idx, 2'b00, wd};
		n = 0;
		do begin
			@(posedge mclk_i);
			n = n + 1;
		end while (ack !== 1'b1 && n < 20);
		rd = dat_r;
		{cyc, stb} <= 2'b00;
		if (ack !== 1'b1) begin
			err_total = err_total + 1;
			end_sim;
		end
	endtask
	task wait_oe(input logic flt, input logic lvl);
		integer n;
		n = 0;
		while (((flt ? f_oe : a_oe) !== lvl) && n < 100000) begin
			@(posedge mclk_i);
			n = n + 1;
		end
		if (n >= 100000) begin
			err_total = err_total + 1;
			end_sim;
		end
	endtask
	task wait_lo(input logic [31:0] exp);
		integer k;
		xfer(1'b0, 3'h5, 32'h0, q);
		for (k = 0; k < 60 && q !== exp; k++) begin
			repeat (500) @(posedge mclk_i);
			xfer(1'b0, 3'h5, 32'h0, q);
		end
	endtask

	// ==========================================
	// Sequence
	initial begin
		mclk_i = 1'b0;
		forever #10 mclk_i = ~mclk_i;
	end
	initial begin
		rst_n_i = 1'b0;
		{cyc, stb, we, adr, dat_w} = '0;
		sel = 4'hf;
		{fan_en, fan_dc} = 2'b11;
		half = 12'h1f4;
		err_total = 0;
		n_checks = 0;
		d = $urandom(32'hbd2033a3);
		repeat (10) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		for (i = 0; i < 8; i++) begin
			xfer(1'b0, i[2:0], 32'h0, q);
			chk(q, rst_v[i]);
		end
		// Random low limit and duty; read-only and unmapped places ignore writes
		for (i = 0; i < 4; i++) begin
			d = $urandom;
			xfer(1'b1, 3'h1, d, q);
			xfer(1'b1, 3'h2, d, q);
			xfer(1'b1, 3'h7, d, q);
			xfer(1'b1, 3'h4, d, q);
			xfer(1'b0, 3'h1, 32'h0, q);
			chk(q, d & 32'hff);
			xfer(1'b0, 3'h2, 32'h0, q);
			chk(q, d & 32'hffff);
			xfer(1'b0, 3'h7, 32'h0, q);
			chk(q, 32'h0);
			xfer(1'b0, 3'h4, 32'h0, q);
			chk(q, 32'h0);
		end
		xfer(1'b1, 3'h2, 32'hffff, q);
		xfer(1'b1, 3'h3, 32'h0, q);
		xfer(1'b1, 3'h1, 32'h80, q);
		for (i = 0; i < 2; i++) begin
			xfer(1'b1, 3'h0, 32'h0f | (i << 4), q);
			wait_lo(exp_cnt(i[0], half));
			chk(q, exp_cnt(i[0], half));
			xfer(1'b0, 3'h6, 32'h0, q);
			chk(q, 32'h0);
		end
		// Overspeed: set once, cleared by read, not rearmed while fast
		xfer(1'b1, 3'h3, 32'h100, q);
		xfer(1'b1, 3'h0, 32'h3f, q);
		wait_oe(1'b0, 1'b1);
		xfer(1'b0, 3'h4, 32'h0, q);
		chk(q & 32'h2, 32'h2);
		repeat (12000) @(posedge mclk_i);
		chk({31'h0, a_oe}, 32'h0);
		xfer(1'b0, 3'h4, 32'h0, q);
		chk(q & 32'h2, 32'h0);
		xfer(1'b1, 3'h3, 32'h0, q);
		// Low duty in tach mode 0: output off, count frozen
		xfer(1'b1, 3'h1, 32'h0, q);
		xfer(1'b1, 3'h0, 32'h0b, q);
		repeat (6000) @(posedge mclk_i);
		half <= 12'h0fa;
		p0 = pwm_hi;
		repeat (12000) @(posedge mclk_i);
		chk(pwm_hi - p0, 32'h0);
		xfer(1'b0, 3'h5, 32'h0, q);
		chk(q, 32'h8);
		// Speed regulation in tach mode 0 lifts zero duty to the floor; no measuring, no debt
		xfer(1'b1, 3'h0, 32'h105, q);
		xfer(1'b1, 3'h0, 32'h101, q);
		repeat (10) @(posedge mclk_i);
		p0 = pwm_hi;
		repeat (4080) @(posedge mclk_i);
		chk(pwm_hi - p0, 32'h4d0);
		// Slow fan: spin-ups, failure after five, release on recovery
		half <= 12'h1f4;
		xfer(1'b1, 3'h1, 32'h80, q);
		xfer(1'b1, 3'h2, 32'h2, q);
		xfer(1'b1, 3'h0, 32'h6f, q);
		wait_oe(1'b1, 1'b1);
		chk({31'h0, a_oe}, 32'h1);
		xfer(1'b1, 3'h2, 32'hffff, q);
		wait_oe(1'b1, 1'b0);
		xfer(1'b0, 3'h4, 32'h0, q);
		chk(q & 32'h5, 32'h1);
		end_sim;
	end
endmodule
